// *** src/seg_scan_pkg.sv ***
// shared constants for the seven-segment scan driver
package seg_scan_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned DIGITS = 4;
   localparam int unsigned SEGS = 7;
   localparam int unsigned NIBBLE_W = 4;
   // time per scan slot in microseconds; 4 slots give a 4 ms refresh
   localparam int unsigned SLOT_US = 1000;
   localparam int unsigned SLOT_CYCLES = (CLK_HZ / 1_000_000) * SLOT_US;
   localparam int unsigned SLOT_CNT_W = $clog2(SLOT_CYCLES);
   localparam logic [SEGS-1:0] SEG_ALL_DARK = 7'h7f;
   localparam logic [DIGITS-1:0] SELECT_NONE = 4'hf;
   localparam logic DP_DARK = 1'b1;
   typedef logic [1:0] slot_t;
   localparam slot_t SLOT_FIRST = 2'h0;
   localparam slot_t SLOT_STEP = 2'h1;
endpackage

// *** src/slot_if.sv ***
// slot tick and current slot index passed from divider to scanner
`timescale 1ns/1ps
interface slot_if;
   logic tick;
   seg_scan_pkg::slot_t slot;
   modport source (output tick, output slot);
   modport sink (input tick, input slot);
endinterface

// *** src/slot_divider.sv ***
// free-running divider producing a slot tick and slot index
`timescale 1ns/1ps
module slot_divider #(
   parameter int unsigned SLOT_CYCLES = seg_scan_pkg::SLOT_CYCLES
) (
   // clock and synchronised reset
   input wire logic clk_sys_in,
   input wire logic nrst_sync_in,
   // slot output
   slot_if.source slot_port
);
   import seg_scan_pkg::*;
   localparam int unsigned CW = $clog2(SLOT_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(SLOT_CYCLES - 1);
   logic [CW-1:0] count;

   always_ff @(posedge clk_sys_in or negedge nrst_sync_in) begin
      if (!nrst_sync_in) begin
         count <= '0;
         slot_port.tick <= 1'b0;
      end else if (count == LAST) begin // RQ10
         count <= '0;
         slot_port.tick <= 1'b1;
      end else begin
         count <= count + CW'(1);
         slot_port.tick <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_sync_in) begin
      if (!nrst_sync_in) begin
         slot_port.slot <= SLOT_FIRST;
      end else if (count == LAST) begin
         slot_port.slot <= slot_port.slot + SLOT_STEP; // RQ7
      end
   end
endmodule // slot_divider

// *** src/seven_segment_scan_driver.sv ***
// four-character seven-segment scan driver, top level
// How it works
// [RQ1] four characters share eight segment lines; each has one select line
// [RQ2] a low segment line lights its segment, high leaves it dark
// [RQ3] segment bits a..g map to outputs a..g; dp goes to selected character
// [RQ4] low select enables a character; bit 3 is leftmost, bit 0 rightmost
// [RQ5] characters with high select stay dark whatever the segment lines
// [RQ6] hex 0..15 encoded active low, letters shaped A b C d E F
// [RQ7] characters are shown in turn so all appear lit
// [RQ8] each slot shows its character's pattern with only its select low
// [RQ9] scanning runs without pause while out of reset
// [RQ10] divider steps slots; 1..16 ms refresh; selects high in reset
// [RQ11] pattern and select change in the same clock cycle
`timescale 1ns/1ps
module seven_segment_scan_driver
   import seg_scan_pkg::*;
#(
   parameter int unsigned SLOT_CYCLES = seg_scan_pkg::SLOT_CYCLES
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   // character values, index 3 is the leftmost character
   input wire logic [seg_scan_pkg::NIBBLE_W-1:0] digit_value_in [4],
   input wire logic [seg_scan_pkg::DIGITS-1:0] decimal_point_on_in,
   input wire logic [seg_scan_pkg::DIGITS-1:0] digit_blank_in,
   // display pins, all active low; bit 0 is segment a, bit 6 segment g
   output logic [seg_scan_pkg::SEGS-1:0] segment_n_out,
   output logic decimal_point_drive_n_out,
   output logic [seg_scan_pkg::DIGITS-1:0] digit_select_n_out
);
   import seg_scan_pkg::*;

   logic rst_meta_n;
   logic rst_n;
   slot_if slot_bus ();

   // reset released through two flops
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_meta_n <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n <= rst_meta_n;
      end
   end

   slot_divider #(
      .SLOT_CYCLES(SLOT_CYCLES)
   ) u_div (
      .clk_sys_in(clk_sys_in),
      .nrst_sync_in(rst_n),
      .slot_port(slot_bus.source)
   );

   // active-low glyph, bit 0 = a .. bit 6 = g
   function automatic logic [SEGS-1:0] hex_glyph(
      input logic [NIBBLE_W-1:0] v
   );
      logic [SEGS-1:0] g;
      g = SEG_ALL_DARK;
      case (v) // RQ6
         4'h0: g = 7'h40;
         4'h1: g = 7'h79;
         4'h2: g = 7'h24;
         4'h3: g = 7'h30;
         4'h4: g = 7'h19;
         4'h5: g = 7'h12;
         4'h6: g = 7'h02;
         4'h7: g = 7'h78;
         4'h8: g = 7'h00;
         4'h9: g = 7'h10;
         4'ha: g = 7'h08;
         4'hb: g = 7'h03;
         4'hc: g = 7'h46;
         4'hd: g = 7'h21;
         4'he: g = 7'h06;
         4'hf: g = 7'h0e;
         default: g = SEG_ALL_DARK;
      endcase
      return g;
   endfunction

   // one-hot active-low select for a slot index
   function automatic logic [DIGITS-1:0] select_for(input slot_t s);
      logic [DIGITS-1:0] m;
      m = SELECT_NONE;
      m[s] = 1'b0;
      return m;
   endfunction

   // the inputs that belong to one character, gathered by slot index
   typedef struct packed {
      logic blank;
      logic dp_on;
      logic [NIBBLE_W-1:0] value;
   } char_s;

   char_s cur;
   logic [SEGS-1:0] next_segment_n;
   logic next_dp_n;
   logic [DIGITS-1:0] next_select_n;

   // cycles since the last slot tick; a divider that stopped would leave
   // one character lit at full duty, so the selects are dropped instead
   localparam int unsigned STALL_LIMIT = SLOT_CYCLES + SLOT_CYCLES;
   localparam int unsigned SW = $clog2(STALL_LIMIT + 1);
   logic [SW-1:0] since_tick;
   logic stalled;

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         since_tick <= '0;
      end else if (slot_bus.tick) begin
         since_tick <= '0;
      end else if (since_tick != SW'(STALL_LIMIT)) begin
         since_tick <= since_tick + SW'(1);
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         stalled <= 1'b0;
      end else begin
         stalled <= since_tick == SW'(STALL_LIMIT); // RQ9
      end
   end

   // the slot index already moved on the tick, so decode it afterwards
   always_comb begin
      cur.blank = digit_blank_in[slot_bus.slot];
      cur.dp_on = decimal_point_on_in[slot_bus.slot];
      cur.value = digit_value_in[slot_bus.slot];
   end

   always_comb begin
      next_segment_n = hex_glyph(cur.value); // RQ3
   end

   always_comb begin
      next_dp_n = ~cur.dp_on; // RQ2
   end

   // a blanked character keeps its select high for its whole slot
   always_comb begin
      next_select_n = select_for(slot_bus.slot); // RQ8
      if (cur.blank || stalled) begin
         next_select_n = SELECT_NONE; // RQ5
      end
   end

   // the pin groups share one clock and one reset, so pattern and select
   // always move on the same edge; inputs changing mid-slot show up at once
   // each unblanked character is lit a quarter of the time, so segment current at
   // the pins is four times what the viewer's brightness suggests
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         segment_n_out <= SEG_ALL_DARK;
      end else begin
         segment_n_out <= next_segment_n; // RQ11
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         decimal_point_drive_n_out <= DP_DARK;
      end else begin
         decimal_point_drive_n_out <= next_dp_n; // RQ1
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         digit_select_n_out <= SELECT_NONE; // RQ10
      end else begin
         digit_select_n_out <= next_select_n; // RQ4 RQ9
      end
   end
endmodule // seven_segment_scan_driver

// *** verification/seg_display_model.sv ***
// display model: latches what each character last showed
`timescale 1ns/1ps
module seg_display_model (
   // clock
   input wire logic clk_sys_in,
   // shared lines and selects, active low
   input wire logic [6:0] segment_n_in,
   input wire logic dp_n_in,
   input wire logic [3:0] select_n_in,
   // last pattern seen per character
   output logic [7:0] seen_out [4]
);
   // unselected characters ignore the shared lines
   always_ff @(posedge clk_sys_in) begin
      for (int i = 0; i < 4; i++) begin
         if (!select_n_in[i]) begin
            seen_out[i] <= {dp_n_in, segment_n_in};
         end
      end
   end
endmodule // seg_display_model

// *** verification/seg_scan_props.sv ***
// assertions on the scan driver pins
`timescale 1ns/1ps
module seg_scan_props #(
   parameter int unsigned SLOT_CYCLES = 8
) (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic [3:0] digit_value_in [4],
   input wire logic [3:0] digit_blank_in,
   input wire logic [6:0] segment_n_out,
   input wire logic [3:0] digit_select_n_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   logic [3:0] s;
   logic [19:0] ins;
   assign s = digit_select_n_out;
   assign ins = {digit_blank_in, digit_value_in[3], digit_value_in[2],
      digit_value_in[1], digit_value_in[0]};
   sequence s_step;
      $changed(s) && s != 4'hf && $past(s) != 4'hf;
   endsequence
   property p_one; $countones(~s) <= 1; endproperty
   a_one: assert property (p_one) else $error("two selects low");
   property p_order; s_step |-> s == 4'({$past(s), $past(s)} >> 3); endproperty
   a_order: assert property (p_order) else $error("bad order");
   property p_hold; $changed(s) |=> $stable(s) [*7]; endproperty
   a_hold: assert property (p_hold) else $error("slot length");
   property p_alive; digit_blank_in == 4'h0 |-> ##[0:9] s != 4'hf; endproperty
   a_alive: assert property (p_alive) else $error("scan stalled");
   property p_edge;
      $changed(segment_n_out) && $past(ins) == $past(ins, 2) |-> $changed(s);
   endproperty
   a_edge: assert property (p_edge) else $error("split change");
   property p_rst;
      disable iff (1'b0) !nrst_in |=> s == 4'hf;
   endproperty
   a_rst: assert property (p_rst) else $error("select in reset");
endmodule // seg_scan_props
bind seven_segment_scan_driver seg_scan_props #(.SLOT_CYCLES(SLOT_CYCLES))
   i_props (.clk_sys_in, .nrst_in, .digit_value_in, .digit_blank_in,
   .segment_n_out, .digit_select_n_out);

// *** verification/seven_segment_scan_driver_tb.sv ***
// self-checking bench for the scan driver
`timescale 1ns/1ps
module seven_segment_scan_driver_tb;
   localparam logic [6:0] glyph [16] = '{7'h40, 7'h79, 7'h24, 7'h30, 7'h19,
      7'h12, 7'h02, 7'h78, 7'h00, 7'h10, 7'h08, 7'h03, 7'h46, 7'h21, 7'h06,
      7'h0e};
   // dp nibble, then values for characters 3..0
   localparam logic [19:0] rows [4] = '{20'h13210, 20'h27654, 20'h4ba98,
      20'h8fedc};
   logic clk_sys_in = 0;
   logic nrst_in = 0;
   logic [3:0] val [4] = '{default: 4'h0};
   logic [3:0] dp_on = 4'h0;
   logic [3:0] blank = 4'h0;
   logic [3:0] sel;
   logic [6:0] seg;
   logic dp_n;
   logic [7:0] seen [4];
   logic [7:0] n;
   int bad_count = 0;
   int compares = 0;
   initial forever #5 clk_sys_in = ~clk_sys_in;
   seven_segment_scan_driver #(.SLOT_CYCLES(8)) i_dut (.clk_sys_in, .nrst_in,
      .digit_value_in(val), .decimal_point_on_in(dp_on),
      .digit_blank_in(blank), .segment_n_out(seg),
      .decimal_point_drive_n_out(dp_n), .digit_select_n_out(sel));
   seg_display_model i_disp (.clk_sys_in, .segment_n_in(seg), .dp_n_in(dp_n),
      .select_n_in(sel), .seen_out(seen));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #4000;
      bad_count++;
      close_out();
   end
   initial begin
      repeat (10) @(posedge clk_sys_in);
      check({4'h0, sel}, 8'h0f);
      nrst_in <= 1'b1;
      foreach (rows[r]) begin
         @(posedge clk_sys_in);
         {dp_on, val[3], val[2], val[1], val[0]} <= rows[r];
         repeat (40) @(posedge clk_sys_in);
         for (int i = 0; i < 4; i++) begin
            check(seen[i], {~rows[r][16+i], glyph[rows[r][4*i+:4]]});
         end
         $display("row %0d done", r);
      end
      // a blanked character must never be selected
      blank <= 4'h2;
      n = 8'h0;
      repeat (44) begin
         @(posedge clk_sys_in);
         n += 8'(sel === 4'hd);
      end
      check(n, 8'h00);
      $display("blank done");
      nrst_in <= 1'b0;
      @(posedge clk_sys_in);
      check({4'h0, sel}, 8'h0f);
      @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      // third edge after release shows slot 0, read one edge later
      repeat (4) @(posedge clk_sys_in);
      check({4'h0, sel}, 8'h0e);
      check({dp_n, seg}, {1'b1, glyph[val[0]]});
      $display("reset done");
      close_out();
   end
endmodule // seven_segment_scan_driver_tb
